/* File: include/mbrfh_defines.svh */
// mbrfh_defines.svh: constants of the read-query handler (function codes, frame layout, limits).
// assumes it is included by its bare name before any code that uses the macros.
`ifndef MBRFH_DEFINES_SVH
`define MBRFH_DEFINES_SVH

// ----------------------------------------------------------------------------
// function and exception codes
// ----------------------------------------------------------------------------
`define MBRFH_FC_COILS 8'h01
`define MBRFH_FC_INPUTS 8'h02
`define MBRFH_FC_HOLD 8'h03
`define MBRFH_EXC_FLAG 8'h80
`define MBRFH_EXC_NONE 8'h00
`define MBRFH_EXC_ILL_FUNC 8'h01
`define MBRFH_EXC_ILL_ADDR 8'h02
`define MBRFH_EXC_ILL_VALUE 8'h03

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define MBRFH_STATION_MIN 8'h01
`define MBRFH_STATION_MAX 8'hf7
`define MBRFH_PROTO_ID 16'h0000
`define MBRFH_REQ_LEN 16'h0006
`define MBRFH_REQ_LAST_POS 4'hb
`define MBRFH_HDR_BYTES 16'h0006
`define MBRFH_PDU_FIXED 16'h0003
`define MBRFH_EXC_PDU 16'h0003
`define MBRFH_POS_COUNT 16'h0008
`define MBRFH_POS_DATA 16'h0009
`define MBRFH_MAX_BITS 16'h07d0
`define MBRFH_MAX_REGS 16'h007d

`endif

/* File: include/mbrfh_pkg.sv */
// mbrfh_pkg.sv: types shared by the read-query handler.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package mbrfh_pkg;
    // gray codes along receive -> check -> send
    typedef enum logic [1:0] {
        MBRFH_RECV = 2'b00,
        MBRFH_CHECK = 2'b01,
        MBRFH_SEND = 2'b11
    } mbrfh_state_e;
endpackage
`default_nettype wire

/* File: rtl/mbrfh_read_handler.sv */
// mbrfh_read_handler.sv: server for read queries 0x01/0x02/0x03 carried in Modbus/TCP frames.
// assumes a byte stream of whole request frames (header included) in, and a byte stream of replies out.
`timescale 1ns/1ns
`default_nettype none
`include "mbrfh_defines.svh"

// Summary of operation
// [R1] A coil readback request is station, 0x01, start address, point count, 16-bit fields high byte first.
// [R2] Station numbers are 1 to 247; requests outside that range are dropped and replies echo the station.
// [R3] Function 0x01 returns the present output readback bits from the start address for the point count.
// [R4] Bit-read replies carry a byte count of (points+7)/8 after the function code, then the packed bytes.
// [R5] Data byte m holds points 8(m-1) to 8m-1 in bit positions 0 to 7, lowest point in bit 0.
// [R6] A failed read replies with the station, the function code with its top bit set, and an exception code.
// [R7] An input read request is station, 0x02, start address, point count, fields high byte first.
// [R8] Function 0x02 returns the input pin states packed eight per byte, lowest point first, count as for coils.
// [R9] A holding read request is station, 0x03, start address and word count, fields high byte first.
// [R10] A holding-register reply carries a byte count of twice the requested word count.
// [R11] Each returned word is sent as two bytes, high byte first then low byte.
// [R12] The holding space read by 0x03 is the whole word array, presets and settings included.
// [R13] The header length field equals the number of bytes after it: 6 in requests, 3 plus data in replies.
// [R14] Each frame opens with transaction id, protocol id zero and length, two bytes each.
// [R15] Only an error sets the top bit of the echoed function code; normal replies echo it unchanged.
// [R16] A range or count outside the implemented space gets an exception reply instead of data.
module mbrfh_read_handler #(
    parameter int NUM_COILS = 16,
    parameter int NUM_INPUTS = 16,
    parameter int NUM_HOLD = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // request byte stream
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxLast,
    output logic rxReady,
    // reply byte stream
    output logic txValid,
    output logic [7:0] txData,
    output logic txLast,
    input wire logic txReady,
    // data sources
    input wire logic [NUM_COILS-1:0] coilReadback,
    input wire logic [NUM_INPUTS-1:0] inputPinState,
    input wire logic [16*NUM_HOLD-1:0] outputWord
);

    typedef struct packed {
        mbrfh_pkg::mbrfh_state_e state;
        logic [3:0] rxPos;
        logic rxBad;
        logic [15:0] tid;
        logic [15:0] pid;
        logic [15:0] len;
        logic [7:0] station;
        logic [7:0] fc;
        logic [15:0] addr;
        logic [15:0] cnt;
        logic [7:0] exc;
        logic [7:0] dataCnt;
        logic [15:0] respLen;
        logic [15:0] txPos;
        logic [7:0] buf0;
        logic [7:0] buf1;
        logic last0;
        logic last1;
        logic v0;
        logic v1;
        logic rxReady;
        logic [NUM_INPUTS-1:0] pinMeta;
        logic [NUM_INPUTS-1:0] pinSync;
    } mbrfh_regs_s;

    mbrfh_regs_s r;
    mbrfh_regs_s next_r;

    // ------------------------------------------------------------------------
    // data byte assembly
    // ------------------------------------------------------------------------
    logic [15:0] dataIdx;
    logic [7:0] bitByte;
    logic [31:0] wordIdx;
    logic [15:0] wordVal;

    assign dataIdx = r.txPos - `MBRFH_POS_DATA;

    genvar j;
    for (j = 0; j < 8; j++) begin : g_bit
        logic [31:0] ofs;
        logic [31:0] pt;
        logic srcBit;
        assign ofs = 32'({dataIdx, 3'b000}) + 32'(j);
        assign pt = 32'(r.addr) + ofs;
        always_comb begin
            srcBit = 1'b0;
            if (r.fc == `MBRFH_FC_COILS) begin
                if (pt < 32'(NUM_COILS)) srcBit = coilReadback[pt]; // [R3]
            end else if (pt < 32'(NUM_INPUTS)) begin
                srcBit = r.pinSync[pt]; // [R8]
            end
        end
        // points past the count pad the last byte with zeros
        assign bitByte[j] = (ofs < 32'(r.cnt)) && srcBit; // [R5]
    end

    assign wordIdx = 32'(r.addr) + 32'(dataIdx[15:1]);
    assign wordVal = (wordIdx < 32'(NUM_HOLD)) ? outputWord[wordIdx*16 +: 16] : 16'h0000; // [R12]

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic [15:0] maxCnt;
        logic [31:0] space;
        logic [7:0] txByte;
        logic txEnd;
        logic push;
        maxCnt = `MBRFH_MAX_BITS;
        space = 32'(NUM_COILS);
        txByte = 8'h00;
        txEnd = 1'b0;
        push = 1'b0;
        next_r = r;
        next_r.pinMeta = inputPinState;
        next_r.pinSync = r.pinMeta;

        // output buffer drains first, but a push needs r.v1 clear, so a slot freed from a full buffer is refilled a cycle later
        if (r.v0 && txReady) begin
            next_r.buf0 = r.buf1;
            next_r.last0 = r.last1;
            next_r.v0 = r.v1;
            next_r.v1 = 1'b0;
        end

        case (r.state)
            mbrfh_pkg::MBRFH_RECV: begin
                if (r.rxReady && rxValid) begin
                    case (r.rxPos) // [R1] [R7] [R9] [R14]
                        4'h0: next_r.tid[15:8] = rxData;
                        4'h1: next_r.tid[7:0] = rxData;
                        4'h2: next_r.pid[15:8] = rxData;
                        4'h3: next_r.pid[7:0] = rxData;
                        4'h4: next_r.len[15:8] = rxData;
                        4'h5: next_r.len[7:0] = rxData;
                        4'h6: next_r.station = rxData;
                        4'h7: next_r.fc = rxData;
                        4'h8: next_r.addr[15:8] = rxData;
                        4'h9: next_r.addr[7:0] = rxData;
                        4'ha: next_r.cnt[15:8] = rxData;
                        4'hb: next_r.cnt[7:0] = rxData;
                        default: next_r.rxBad = 1'b1;
                    endcase
                    if (r.rxPos != 4'hf) next_r.rxPos = r.rxPos + 4'h1;
                    if (rxLast) begin
                        next_r.rxPos = 4'h0;
                        next_r.rxBad = 1'b0;
                        if (!r.rxBad && r.rxPos == `MBRFH_REQ_LAST_POS) next_r.state = mbrfh_pkg::MBRFH_CHECK;
                    end
                end
            end
            mbrfh_pkg::MBRFH_CHECK: begin
                next_r.state = mbrfh_pkg::MBRFH_SEND;
                next_r.txPos = 16'h0000;
                if (r.fc == `MBRFH_FC_HOLD) begin
                    maxCnt = `MBRFH_MAX_REGS;
                    space = 32'(NUM_HOLD);
                end else if (r.fc == `MBRFH_FC_INPUTS) begin
                    space = 32'(NUM_INPUTS);
                end
                if (r.fc != `MBRFH_FC_COILS && r.fc != `MBRFH_FC_INPUTS && r.fc != `MBRFH_FC_HOLD)
                    next_r.exc = `MBRFH_EXC_ILL_FUNC;
                else if (r.cnt == 16'h0000 || r.cnt > maxCnt)
                    next_r.exc = `MBRFH_EXC_ILL_VALUE; // [R16]
                else if (32'(r.addr) + 32'(r.cnt) > space)
                    next_r.exc = `MBRFH_EXC_ILL_ADDR; // [R16]
                else
                    next_r.exc = `MBRFH_EXC_NONE;
                if (r.fc == `MBRFH_FC_HOLD) next_r.dataCnt = r.cnt[6:0] * 8'h02; // [R10]
                else next_r.dataCnt = 8'((r.cnt + 16'h0007) >> 3); // [R4]
                if (next_r.exc != `MBRFH_EXC_NONE) next_r.respLen = `MBRFH_EXC_PDU; // [R13]
                else next_r.respLen = `MBRFH_PDU_FIXED + 16'(next_r.dataCnt); // [R13]
                // malformed header or out-of-range station: drop silently
                if (r.pid != `MBRFH_PROTO_ID || r.len != `MBRFH_REQ_LEN) next_r.state = mbrfh_pkg::MBRFH_RECV;
                if (r.station < `MBRFH_STATION_MIN || r.station > `MBRFH_STATION_MAX) // [R2]
                    next_r.state = mbrfh_pkg::MBRFH_RECV;
            end
            mbrfh_pkg::MBRFH_SEND: begin
                case (r.txPos)
                    16'h0000: txByte = r.tid[15:8];
                    16'h0001: txByte = r.tid[7:0];
                    16'h0002: txByte = 8'(`MBRFH_PROTO_ID >> 8);
                    16'h0003: txByte = 8'(`MBRFH_PROTO_ID);
                    16'h0004: txByte = r.respLen[15:8];
                    16'h0005: txByte = r.respLen[7:0];
                    16'h0006: txByte = r.station; // [R2]
                    16'h0007: txByte = (r.exc != `MBRFH_EXC_NONE) ? (r.fc | `MBRFH_EXC_FLAG) : r.fc; // [R6] [R15]
                    16'h0008: txByte = (r.exc != `MBRFH_EXC_NONE) ? r.exc : r.dataCnt; // [R6] [R4]
                    default: begin
                        if (r.fc == `MBRFH_FC_HOLD) txByte = dataIdx[0] ? wordVal[7:0] : wordVal[15:8]; // [R11]
                        else txByte = bitByte; // [R5]
                    end
                endcase
                txEnd = (r.txPos == `MBRFH_HDR_BYTES + r.respLen - 16'h0001);
                push = !r.v1;
                if (push) begin
                    if (!next_r.v0) begin
                        next_r.buf0 = txByte;
                        next_r.last0 = txEnd;
                        next_r.v0 = 1'b1;
                    end else begin
                        next_r.buf1 = txByte;
                        next_r.last1 = txEnd;
                        next_r.v1 = 1'b1;
                    end
                    next_r.txPos = r.txPos + 16'h0001;
                    if (txEnd) next_r.state = mbrfh_pkg::MBRFH_RECV;
                end
            end
            default: next_r.state = mbrfh_pkg::MBRFH_RECV;
        endcase
        // one request at a time: intake closes from request end until the last reply byte is queued, not until it drains
        next_r.rxReady = (next_r.state == mbrfh_pkg::MBRFH_RECV);
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rxReady = r.rxReady;
    assign txValid = r.v0;
    assign txData = r.buf0;
    assign txLast = r.last0;

endmodule // mbrfh_read_handler
`default_nettype wire

/* File: tb/mbrfh_read_handler_assertions.sv */
// mbrfh_read_handler_assertions.sv: port checker of the read-query handler, bound below.
// assumes one clock domain, sys_clk, with nrst as its asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module mbrfh_read_handler_assertions (
    // handler ports watched
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic rxLast,
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txLast,
    input wire logic txReady
);
    logic [7:0] pos;
    logic [7:0] lenLo;
    logic fcTop;
    logic [7:0] rxCnt;
    wire logic beat = txValid && txReady;
    // only a full twelve-byte frame closes intake; a short or long one is dropped with intake left open
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) rxCnt <= 8'h00;
        else if (rxValid && rxReady) rxCnt <= rxLast ? 8'h00 : rxCnt + 8'h01;
    end
    // position restarts on txLast, so one bad reply cannot skew the next
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) {pos, lenLo, fcTop} <= '0;
        else if (beat) begin
            pos <= txLast ? 8'h00 : pos + 8'h01;
            lenLo <= (pos == 8'h05) ? txData : lenLo;
            fcTop <= (pos == 8'h07) ? txData[7] : fcTop;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
        else $error("reply moved while stalled");
    chk_rx_pause: assert property (rxValid && rxReady && rxLast && rxCnt == 8'h0b |=> !rxReady)
        else $error("byte taken after frame end");
    chk_hdr_zero: assert property (beat && pos inside {8'h02, 8'h03, 8'h04} |-> txData == 8'h00)
        else $error("header byte not zero");
    chk_station_ok: assert property (beat && pos == 8'h06 |-> txData inside {[8'h01:8'hf7]})
        else $error("station out of range");
    chk_exc_end: assert property (beat && pos == 8'h08 |-> txLast == fcTop)
        else $error("exception size wrong");
    chk_len_total: assert property (beat && txLast |-> pos == lenLo + 8'h05)
        else $error("length field wrong");
    chk_byte_count: assert property (beat && pos == 8'h08 && !fcTop |-> lenLo == txData + 8'h03)
        else $error("byte count wrong");
    chk_exc_size: assert property (beat && pos == 8'h08 && fcTop |-> lenLo == 8'h03)
        else $error("exception length wrong");
endmodule // mbrfh_read_handler_assertions
bind mbrfh_read_handler mbrfh_read_handler_assertions i_chk (.sys_clk(sys_clk), .nrst(nrst), .rxValid(rxValid),
    .rxReady(rxReady), .rxLast(rxLast), .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady));
`default_nettype wire

/* File: tb/mbrfh_client_model.sv */
// mbrfh_client_model.sv: remote client sending one request frame per start pulse.
// assumes start and frame change at a falling edge; the bench collects the reply.
`timescale 1ns/1ns
`default_nettype none
module mbrfh_client_model (
    // bench control and handler streams
    input wire logic sys_clk,
    input wire logic start,
    input wire logic slow,
    input wire logic [95:0] frame,
    input wire logic rxReady,
    output logic rxValid = 1'b0,
    output logic [7:0] rxData = 8'h00,
    output logic rxLast = 1'b0,
    output logic txReady = 1'b1
);
    int idx = 0;
    logic took = 1'b0;
    always @(posedge sys_clk) took <= rxValid && rxReady;
    // slow halves the drain rate so the reply buffer fills and stalls
    always @(negedge sys_clk) begin
        txReady <= !slow || !txReady;
        if (rxValid && took && rxLast) begin
            rxValid <= 1'b0;
            rxLast <= 1'b0;
            rxData <= ~rxData;
        end else if (rxValid && took) begin
            idx = idx + 1;
            rxData <= frame[95 - 8 * idx -: 8];
            rxLast <= idx == 11;
        end else if (start && !rxValid) begin
            idx = 0;
            rxValid <= 1'b1;
            rxData <= frame[95 -: 8];
        end
    end
endmodule // mbrfh_client_model
`default_nettype wire

/* File: tb/mbrfh_read_handler_bench.sv */
// mbrfh_read_handler_bench.sv: self-checking bench of the read-query handler.
// assumes the client model and the bound checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %s", $time, m); end end
module mbrfh_read_handler_bench;
    logic sys_clk = 1'b0, nrst = 1'b0, start = 1'b0, slow = 1'b0, done = 1'b0;
    logic rxValid, rxLast, rxReady, txValid, txLast, txReady;
    logic [7:0] rxData, txData, e [0:31], rsp [0:31];
    logic [15:0] coils = 16'hc5a3, pins = 16'h3c96;
    logic [255:0] words = '0;
    logic [95:0] frame = '0;
    logic [31:0] hdr = 32'h0000_0006;
    int rspCnt = 0, fail_count = 0, num_checks = 0;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        done <= !start && (done || (txValid && txReady && txLast));
        rspCnt <= start ? 0 : rspCnt + int'(txValid && txReady);
        if (txValid && txReady) rsp[rspCnt[4:0]] <= txData;
    end
    mbrfh_read_handler i_dut (.sys_clk(sys_clk), .nrst(nrst), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast),
        .rxReady(rxReady), .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
        .coilReadback(coils), .inputPinState(pins), .outputWord(words));
    mbrfh_client_model i_cli (.sys_clk(sys_clk), .start(start), .slow(slow), .frame(frame), .rxReady(rxReady),
        .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .txReady(txReady));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // n is the expected reply length, 0 when the frame must be dropped
    task automatic run(input logic [7:0] st, fc, input logic [15:0] adr, cnt, input int n);
        int k;
        k = 0;
        frame = {8'h5a, fc, hdr, st, fc, adr, cnt};
        {e[0], e[1], e[2], e[3], e[4], e[5], e[6]} = {8'h5a, fc, 24'h000000, 8'(n - 6), st};
        @(negedge sys_clk);
        start <= 1'b1;
        @(negedge sys_clk);
        start <= 1'b0;
        while (done !== 1'b1 && k < 300) begin
            @(negedge sys_clk);
            k++;
        end
        if (n > 0 && k == 300) begin
            fail_count++;
            end_of_test;
        end
        `CHK(rspCnt, n, "reply length")
        for (int i = 0; i < n; i++) `CHK(rsp[i], e[i], "reply byte")
    endtask
    task automatic t_read(input logic [7:0] st, fc, input logic [15:0] adr, cnt, input logic s);
        logic [15:0] src;
        int bc;
        src = (fc == 8'h01) ? coils : pins;
        bc = (fc == 8'h03) ? 2 * cnt : (cnt + 7) / 8;
        slow = s;
        e[7] = fc;
        e[8] = 8'(bc);
        for (int m = 0; m < bc; m++) begin
            for (int j = 0; j < 8; j++) e[9 + m][j] = 8 * m + j < cnt && src[adr + 8 * m + j];
            if (fc == 8'h03) e[9 + m] = words[16 * (adr + m / 2) + 8 * (1 - m % 2) +: 8];
        end
        run(st, fc, adr, cnt, 9 + bc);
        $display("read %0h from %0h done", fc, adr);
    endtask
    task automatic t_errors;
        logic [47:0] tab [0:4] = '{48'h04_0000_0001_01, 48'h03_0000_0000_03, 48'h02_000f_0002_02,
            48'h01_0000_0011_02, 48'h03_0000_007e_03};
        slow = 1'b0;
        foreach (tab[i]) begin
            e[7] = tab[i][47:40] | 8'h80;
            e[8] = tab[i][7:0];
            run(8'h11, tab[i][47:40], tab[i][39:24], tab[i][23:8], 9);
        end
        $display("exceptions done");
    endtask
    task automatic t_drop;
        run(8'h00, 8'h01, 16'h0000, 16'h0001, 0);
        run(8'hf8, 8'h01, 16'h0000, 16'h0001, 0);
        hdr = 32'h0001_0006;
        run(8'h11, 8'h01, 16'h0000, 16'h0001, 0);
        hdr = 32'h0000_0007;
        run(8'h11, 8'h01, 16'h0000, 16'h0001, 0);
        hdr = 32'h0000_0006;
        $display("dropped stations done");
    endtask
    initial begin
        for (int k = 0; k < 16; k++) words[16 * k +: 16] = 16'(k * 16'h1357);
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        t_read(8'h01, 8'h01, 16'h0000, 16'h0002, 1'b0);
        t_read(8'hf7, 8'h02, 16'h0003, 16'h000a, 1'b1);
        t_read(8'h11, 8'h01, 16'h0000, 16'h0010, 1'b1);
        t_read(8'h11, 8'h03, 16'h000e, 16'h0002, 1'b1);
        t_errors;
        t_drop;
        t_read(8'h11, 8'h03, 16'h0000, 16'h0001, 1'b0);
        end_of_test;
    end
endmodule // mbrfh_read_handler_bench
`default_nettype wire
